/* File: sacc_top.sv */
/*
 * sacc_top: enable, conversion clock dividers, start-source selection,
 * track/convert sequencing, calibration sequencing and sticky flags for two
 * successive-approximation converters behind a special-function-register port.
 * Assumes all inputs synchronous to core_clk except the external strobe, and
 * that the analogue side takes the strobe and phase outputs as levels.
 */
`timescale 1ns/10ps

// Contract
// - converter runs only while its enable is set
// - converter 0 clock is divider plus one
// - converter 1 has own divider and calibration
// - gain calibration starts only when idle
// - linearity calibration starts only when idle
// - offset calibration starts only when idle
// - busy during conversion, done on falling edge
// - writing busy starts only with source 00
// - start source selects write, timers, strobe
// - track mode inserts tracking before conversion
// - otherwise track continuously except while converting
// - done flag sticky until software clears
// - window flag sticky until software clears
// - control register resets to all zeros
module sacc_top #(
	parameter int TRACK_CLKS = sacc_pkg::SACC_TRACK_CLKS,
	parameter int CONV_CLKS = sacc_pkg::SACC_CONV_CLKS,
	parameter int CAL_CLKS = sacc_pkg::SACC_CAL_CLKS
) (
	input wire logic core_clk,	// system clock
	input wire logic rst_b,	// async reset, active low
	input wire sacc_pkg::sacc_sfr_req_t sfr_req,	// register port request
	output logic [7:0] sfr_rdata,	// read data, one cycle after rd
	input wire logic conv1_enable,	// converter 1 enable
	input wire logic timer2_overflow,	// timer 2 overflow pulse
	input wire logic timer3_overflow,	// timer 3 overflow pulse
	input wire logic external_convert_strobe,	// asynchronous start strobe
	input wire logic window_hit,	// window comparator, valid at conversion end
	output logic [1:0] conv_powered,	// converter out of shutdown
	output logic [1:0] conv_clk_tick,	// one pulse per conversion clock
	output logic [1:0] cal_active,	// calibration running
	output logic [1:0] cal_external_ref,	// external calibration voltages
	output logic conv0_tracking,	// track-and-hold tracking
	output logic conv0_converting	// conversion phase
);
	import sacc_pkg::*;

	// phase counters are SACC_PHASE_W bits wide
	if (TRACK_CLKS < 1 || CONV_CLKS < 1 || CAL_CLKS < 1 ||
		TRACK_CLKS > 255 || CONV_CLKS > 255 || CAL_CLKS > 255) begin : g_bad_len
		$error("sacc_top: phase lengths must be 1 to 255");
	end

	localparam logic [SACC_PHASE_W-1:0] TRACK_LAST = SACC_PHASE_W'(TRACK_CLKS - 1);
	localparam logic [SACC_PHASE_W-1:0] CONV_LAST = SACC_PHASE_W'(CONV_CLKS - 1);
	localparam logic [SACC_PHASE_W-1:0] CAL_LAST = SACC_PHASE_W'(CAL_CLKS - 1);

	function automatic logic sel_reg(input sacc_sfr_req_t r, input logic [3:0] pg,
		input logic [7:0] ofs);
		sel_reg = (r.page == pg) && (r.addr == ofs);
	endfunction : sel_reg

	sacc_cfg_t cfg_q [2];
	sacc_ctl_t ctl_q;
	sacc_ctl_t ctl_d;
	sacc_state_t state_q;
	sacc_state_t state_d;
	logic [SACC_PHASE_W-1:0] phase_q;
	logic [SACC_PHASE_W-1:0] phase_d;
	logic [2:0] strobe_sync_q;
	logic [7:0] rdata_q;

	wire cfg_sel [2];
	assign cfg_sel[0] = sel_reg(sfr_req, SACC_PAGE0, SACC_CFG_OFS);
	assign cfg_sel[1] = sel_reg(sfr_req, SACC_PAGE1, SACC_CFG_OFS);
	wire ctl_sel = sel_reg(sfr_req, SACC_PAGE0, SACC_CTL_OFS);
	wire ctl_wr = sfr_req.wr && ctl_sel;
	sacc_ctl_t ctl_wdata;
	assign ctl_wdata = sacc_ctl_t'(sfr_req.wdata);

	wire [1:0] enable = {conv1_enable, ctl_q.converter_enable};
	wire seq_idle = (state_q == SACC_IDLE);

	// strobe: two flops to resolve, third for the edge only
	wire strobe_rise = strobe_sync_q[1] && !strobe_sync_q[2];

	// start trigger selection
	logic trig_sel;
	always_comb begin
		case (ctl_q.start_source_select)
			SACC_SRC_WRITE: trig_sel = ctl_wr && ctl_wdata.conversion_busy;
			SACC_SRC_TMR3: trig_sel = timer3_overflow;
			SACC_SRC_STRB: trig_sel = strobe_rise;
			SACC_SRC_TMR2: trig_sel = timer2_overflow;
			default: trig_sel = 1'b0;
		endcase
	end

	// per-converter divider and calibration engine
	logic [3:0] div_cnt_q [2];
	logic [SACC_PHASE_W-1:0] cal_cnt_q [2];
	wire [1:0] tick;
	wire [1:0] cal_run;
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_conv
			wire idle_i = (gi == 0) ? seq_idle : 1'b1;
			wire run_i = cfg_q[gi].gain_cal_trigger || cfg_q[gi].linearity_cal_trigger ||
				cfg_q[gi].offset_cal_trigger;
			// dropped, not queued, if a conversion or calibration is in flight
			wire start_i = sfr_req.wr && cfg_sel[gi] && enable[gi] && idle_i &&
				!run_i && (sfr_req.wdata[2:0] != 3'h0);
			wire done_i = run_i && tick[gi] && (cal_cnt_q[gi] == CAL_LAST);
			assign tick[gi] = enable[gi] && (div_cnt_q[gi] == cfg_q[gi].clock_divider);
			assign cal_run[gi] = run_i;

			always_ff @(posedge core_clk or negedge rst_b) begin
				if (!rst_b) begin
					div_cnt_q[gi] <= 4'h0;
				end else if (!enable[gi] || tick[gi]) begin
					div_cnt_q[gi] <= 4'h0;
				end else begin
					div_cnt_q[gi] <= div_cnt_q[gi] + 4'h1;
				end
			end

			always_ff @(posedge core_clk or negedge rst_b) begin
				if (!rst_b) begin
					cal_cnt_q[gi] <= '0;
				end else if (!run_i) begin
					cal_cnt_q[gi] <= '0;
				end else if (tick[gi]) begin
					cal_cnt_q[gi] <= cal_cnt_q[gi] + SACC_PHASE_W'(1);
				end
			end

			always_ff @(posedge core_clk or negedge rst_b) begin
				if (!rst_b) begin
					cfg_q[gi] <= sacc_cfg_t'(SACC_CFG_RST);
				end else begin
					if (sfr_req.wr && cfg_sel[gi]) begin
						cfg_q[gi].clock_divider <= sfr_req.wdata[7:4];
						cfg_q[gi].cal_source_select <= sfr_req.wdata[3];
					end
					if (start_i) begin
						// writing 0 to a trigger bit leaves it alone
						cfg_q[gi].gain_cal_trigger <= sfr_req.wdata[2];
						cfg_q[gi].linearity_cal_trigger <= sfr_req.wdata[1];
						cfg_q[gi].offset_cal_trigger <= sfr_req.wdata[0];
					end else if (done_i || !enable[gi]) begin
						// shutdown aborts a calibration in flight
						cfg_q[gi].gain_cal_trigger <= 1'b0;
						cfg_q[gi].linearity_cal_trigger <= 1'b0;
						cfg_q[gi].offset_cal_trigger <= 1'b0;
					end
				end
			end
		end
	endgenerate

	// converter 0 track/convert sequencer
	wire accept = seq_idle && enable[0] && !cal_run[0] && trig_sel;
	wire phase_end_track = tick[0] && (phase_q == TRACK_LAST);
	wire phase_end_conv = tick[0] && (phase_q == CONV_LAST);
	always_comb begin
		state_d = state_q;
		phase_d = tick[0] ? phase_q + SACC_PHASE_W'(1) : phase_q;
		case (state_q)
			SACC_IDLE: begin
				phase_d = '0;
				if (accept) begin
					state_d = ctl_q.track_mode_select ? SACC_TRACK : SACC_CONV;
				end
			end
			SACC_TRACK: begin
				if (phase_end_track) begin
					state_d = SACC_CONV;
					phase_d = '0;
				end
			end
			SACC_CONV: begin
				if (phase_end_conv) begin
					state_d = SACC_IDLE;
					phase_d = '0;
				end
			end
			default: begin
				state_d = SACC_IDLE;
				phase_d = '0;
			end
		endcase
		if (!enable[0]) begin
			state_d = SACC_IDLE;
			phase_d = '0;
		end
	end

	// done rises on the edge busy drops; a shutdown abort is no completion
	wire busy_fall = (state_q == SACC_CONV) && phase_end_conv;
	wire win_set = (state_q == SACC_CONV) && phase_end_conv && window_hit;

	// control register next value; hardware sets win over software clears
	always_comb begin
		ctl_d = ctl_q;
		if (ctl_wr) begin
			ctl_d.converter_enable = ctl_wdata.converter_enable;
			ctl_d.track_mode_select = ctl_wdata.track_mode_select;
			ctl_d.conversion_done_flag = ctl_wdata.conversion_done_flag;
			ctl_d.start_source_select = ctl_wdata.start_source_select;
			ctl_d.window_match_flag = ctl_wdata.window_match_flag;
		end
		ctl_d.conversion_done_flag = ctl_d.conversion_done_flag || busy_fall;
		ctl_d.window_match_flag = ctl_d.window_match_flag || win_set;
		ctl_d.conversion_busy = (state_d != SACC_IDLE);
		ctl_d.unused = 1'b0;
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctl_q <= sacc_ctl_t'(SACC_CTL_RST);
			state_q <= SACC_IDLE;
			phase_q <= '0;
		end else begin
			ctl_q <= ctl_d;
			state_q <= state_d;
			phase_q <= phase_d;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			strobe_sync_q <= 3'h0;
		end else begin
			strobe_sync_q <= {strobe_sync_q[1:0], external_convert_strobe};
		end
	end

	// read data registered; unmapped addresses read 0
	wire [7:0] rd_mux = cfg_sel[0] ? 8'(cfg_q[0]) :
		cfg_sel[1] ? 8'(cfg_q[1]) :
		ctl_sel ? 8'(ctl_q) : 8'h00;
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata_q <= 8'h00;
		end else if (sfr_req.rd) begin
			rdata_q <= rd_mux;
		end
	end

	assign sfr_rdata = rdata_q;
	assign conv_powered = enable;
	assign conv_clk_tick = tick;
	// state clears one edge after enable drops, so outputs are gated now
	assign cal_active = cal_run & enable;
	assign cal_external_ref = {cfg_q[1].cal_source_select, cfg_q[0].cal_source_select};
	// continuous tracking when track mode is off, explicit phase otherwise
	assign conv0_tracking = enable[0] && (ctl_q.track_mode_select ?
		(state_q == SACC_TRACK) : (state_q != SACC_CONV));
	assign conv0_converting = enable[0] && (state_q == SACC_CONV);

endmodule : sacc_top

/* File: sacc_pkg.sv */
/*
 * sacc_pkg: register map, field layouts, reset values, sequencer states and
 * default timing for the two-converter control and calibration block.
 * Assumes an 8-bit special-function-register port with a page select.
 */
package sacc_pkg;

	// register offsets and pages
	localparam logic [7:0] SACC_CFG_OFS = 8'hbc;	// both configuration registers
	localparam logic [7:0] SACC_CTL_OFS = 8'he8;	// converter 0 control
	localparam logic [3:0] SACC_PAGE0 = 4'h0;
	localparam logic [3:0] SACC_PAGE1 = 4'h1;

	// reset values
	localparam logic [7:0] SACC_CFG_RST = 8'hf0;
	localparam logic [7:0] SACC_CTL_RST = 8'h00;

	// start-source codes
	localparam logic [1:0] SACC_SRC_WRITE = 2'h0;
	localparam logic [1:0] SACC_SRC_TMR3 = 2'h1;
	localparam logic [1:0] SACC_SRC_STRB = 2'h2;
	localparam logic [1:0] SACC_SRC_TMR2 = 2'h3;

	// default phase lengths in conversion clocks
	localparam int SACC_TRACK_CLKS = 3;
	localparam int SACC_CONV_CLKS = 16;
	localparam int SACC_CAL_CLKS = 64;
	localparam int SACC_PHASE_W = 8;

	// configuration register layout, msb first
	typedef struct packed {
		logic [3:0] clock_divider;	// bits 7-4
		logic cal_source_select;	// bit 3
		logic gain_cal_trigger;	// bit 2
		logic linearity_cal_trigger;	// bit 1
		logic offset_cal_trigger;	// bit 0
	} sacc_cfg_t;

	// converter 0 control register layout, msb first
	typedef struct packed {
		logic converter_enable;	// bit 7
		logic track_mode_select;	// bit 6
		logic conversion_done_flag;	// bit 5
		logic conversion_busy;	// bit 4
		logic [1:0] start_source_select;	// bits 3-2
		logic window_match_flag;	// bit 1
		logic unused;	// bit 0, reads 0
	} sacc_ctl_t;

	// register port request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [3:0] page;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sacc_sfr_req_t;

	// converter 0 sequencer, gray along idle-track-convert
	typedef enum logic [1:0] {
		SACC_IDLE = 2'b00,
		SACC_TRACK = 2'b01,
		SACC_CONV = 2'b11
	} sacc_state_t;

endpackage : sacc_pkg

/* File: sacc_chk_assertions.sv */
/* sacc_chk: port assertions for sacc_top.
   assumes one core_clk domain and rst_b active low. */
`timescale 1ns/10ps
module sacc_chk (
	input wire logic core_clk,	// clock
	input wire logic rst_b,	// reset
	input wire sacc_pkg::sacc_sfr_req_t sfr_req,	// request
	input wire logic [7:0] sfr_rdata,	// read data
	input wire logic [1:0] conv_powered,	// powered
	input wire logic [1:0] conv_clk_tick,	// ticks
	input wire logic [1:0] cal_active,	// calibrating
	input wire logic [1:0] cal_external_ref,	// cal source
	input wire logic conv0_tracking,	// tracking
	input wire logic conv0_converting	// converting
);
	import sacc_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	wire cfg_hit = sfr_req.wr && sfr_req.addr == SACC_CFG_OFS;
	wire cfg0_wr = cfg_hit && sfr_req.page == SACC_PAGE0;
	wire cfg1_wr = cfg_hit && sfr_req.page == SACC_PAGE1;
	wire map_cfg = sfr_req.addr == SACC_CFG_OFS && sfr_req.page <= SACC_PAGE1;
	wire map_ctl = sfr_req.addr == SACC_CTL_OFS && sfr_req.page == SACC_PAGE0;
	wire unmap_rd = sfr_req.rd && !map_cfg && !map_ctl;
	wire idle0 = conv_powered[0] && !cal_active[0] && !conv0_converting && !conv0_tracking;
	sequence s_conv_end;
		conv0_converting ##1 !conv0_converting && conv_powered[0];
	endsequence
	property p_off0;
		!conv_powered[0] |-> !conv0_converting && !cal_active[0] && !conv_clk_tick[0];
	endproperty
	a_off0: assert property (p_off0) else $error("converter 0 active while off");
	property p_off1;
		!conv_powered[1] |-> !cal_active[1] && !conv_clk_tick[1];
	endproperty
	a_off1: assert property (p_off1) else $error("converter 1 active while off");
	property p_phase;
		!(conv0_tracking && conv0_converting);
	endproperty
	a_phase: assert property (p_phase) else $error("tracking during conversion");
	property p_unmap;
		unmap_rd ##1 !sfr_req.rd |=> sfr_rdata == 8'h00;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	property p_cal_go;
		cfg0_wr && sfr_req.wdata[2:0] != 3'h0 && idle0 |=> cal_active[0];
	endproperty
	a_cal_go: assert property (p_cal_go) else $error("calibration did not start");
	property p_cal_off;
		cfg0_wr && !conv_powered[0] |=> !cal_active[0];
	endproperty
	a_cal_off: assert property (p_cal_off) else $error("calibration while off");
	property p_src;
		cfg1_wr |=> cal_external_ref[1] == $past(sfr_req.wdata[3]);
	endproperty
	a_src: assert property (p_src) else $error("cal source not taken");
	property p_conv_end;
		s_conv_end |-> $past(conv_clk_tick[0]);
	endproperty
	a_conv_end: assert property (p_conv_end) else $error("conversion ended off tick");
endmodule : sacc_chk
bind sacc_top sacc_chk chk (.core_clk(core_clk), .rst_b(rst_b), .sfr_req(sfr_req),
	.sfr_rdata(sfr_rdata), .conv_powered(conv_powered), .conv_clk_tick(conv_clk_tick),
	.cal_active(cal_active), .cal_external_ref(cal_external_ref),
	.conv0_tracking(conv0_tracking), .conv0_converting(conv0_converting));

/* File: sacc_sw_model.sv */
/* sacc_sw_model: software side issuing register accesses.
   assumes reads answer within two edges and hold. */
`timescale 1ns/10ps
module sacc_sw_model (
	input wire logic core_clk,	// clock
	input wire logic [7:0] sfr_rdata,	// read data
	output sacc_pkg::sacc_sfr_req_t sfr_req	// request
);
	import sacc_pkg::*;
	initial sfr_req = '0;
	task automatic access(input logic w, input logic [3:0] pg, input logic [7:0] a, d,
		output logic [7:0] q);
		logic [7:0] v;
		v = d;
		// never program a conversion clock above 25 MHz
		if (w && a == SACC_CFG_OFS && v[7:4] < 4'h9)
			v[7:4] = 4'h9;
		@(posedge core_clk);
		sfr_req <= '{wr: w, rd: !w, page: pg, addr: a, wdata: v};
		@(posedge core_clk);
		sfr_req.wr <= 1'h0;
		sfr_req.rd <= 1'h0;
		@(posedge core_clk);
		#1 q = sfr_rdata;
	endtask : access
endmodule : sacc_sw_model

/* File: tb.sv */
/* tb: scenario tasks for sacc_top through its register port.
   assumes sacc_sw_model as software and a 250 MHz clock. */
`timescale 1ns/10ps
module tb;
	import sacc_pkg::*;
	logic core_clk, rst_b, en1, hit;
	logic [2:0] trig;
	sacc_sfr_req_t req;
	logic [7:0] rdata, q;
	logic [1:0] pwr, tick, cal, xref;
	logic trk, cnv;
	int err_count = 0, samples_checked = 0, n;
	sacc_top #(.TRACK_CLKS(2), .CONV_CLKS(4), .CAL_CLKS(4)) dut (.core_clk(core_clk),
		.rst_b(rst_b), .sfr_req(req), .sfr_rdata(rdata), .conv1_enable(en1),
		.timer2_overflow(trig[2]), .timer3_overflow(trig[0]),
		.external_convert_strobe(trig[1]), .window_hit(hit), .conv_powered(pwr),
		.conv_clk_tick(tick), .cal_active(cal), .cal_external_ref(xref),
		.conv0_tracking(trk), .conv0_converting(cnv));
	sacc_sw_model sw (.core_clk(core_clk), .sfr_rdata(rdata), .sfr_req(req));
	initial begin
		core_clk = 1'h0;
		forever #2 core_clk = ~core_clk;
	end
	task check(input logic [7:0] got, exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task give_verdict;
		$display("comparisons %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : give_verdict
	task wr(input logic [3:0] pg, input logic [7:0] a, d);
		sw.access(1'h1, pg, a, d, q);
	endtask : wr
	task rd(input logic [3:0] pg, input logic [7:0] a, exp);
		sw.access(1'h0, pg, a, 8'h00, q);
		check(q, exp);
	endtask : rd
	function logic sig(input int s);
		logic [5:0] v;
		v = {cal[1], tick, cal[0], trk, cnv};
		return v[s];
	endfunction : sig
	// bounded wait; n counts the edges spent
	task wait_lvl(input int s, input logic lvl);
		n = 0;
		while (sig(s) !== lvl) begin
			@(posedge core_clk);
			#1 n++;
			if (n > 400) begin
				err_count++;
				give_verdict;
			end
		end
	endtask : wait_lvl
	task gap(input int s, input logic [7:0] exp);
		wait_lvl(s, 1'h1);
		@(posedge core_clk);
		#1 wait_lvl(s, 1'h1);
		check(8'(n + 1), exp);
	endtask : gap
	task t_reset;
		check({2'h0, pwr, cal, cnv, trk}, 8'h00);
		rd(4'h0, 8'hbc, 8'hf0);
		rd(4'h1, 8'hbc, 8'hf0);
		rd(4'h0, 8'he8, 8'h00);
		rd(4'h0, 8'h55, 8'h00);
		$display("reset test done");
	endtask : t_reset
	task t_divider;
		wr(4'h0, 8'hbc, 8'h90);
		wr(4'h0, 8'he8, 8'h80);
		@(posedge core_clk) en1 <= 1'h1;
		gap(3, 8'd10);
		gap(4, 8'd16);
		wr(4'h1, 8'hbc, 8'hf8);
		check({7'h0, xref[1]}, 8'h01);
		$display("divider test done");
	endtask : t_divider
	task t_sw_conv;
		check({7'h0, trk}, 8'h01);
		@(posedge core_clk) hit <= 1'h1;
		wr(4'h0, 8'he8, 8'h90);
		check({7'h0, cnv}, 8'h01);
		rd(4'h0, 8'he8, 8'h90);
		wait_lvl(0, 1'h0);
		@(posedge core_clk) hit <= 1'h0;
		rd(4'h0, 8'he8, 8'ha2);
		wr(4'h0, 8'he8, 8'h80);
		rd(4'h0, 8'he8, 8'h80);
		$display("software conversion test done");
	endtask : t_sw_conv
	task t_sources;
		for (int s = 1; s < 4; s++) begin
			wr(4'h0, 8'he8, 8'h80 | 8'(s << 2));
			wr(4'h0, 8'he8, 8'h90 | 8'(s << 2));
			check({7'h0, cnv}, 8'h00);
			@(posedge core_clk) trig[s - 1] <= 1'h1;
			// strobe stays high: only its edge may start a conversion
			@(posedge core_clk) trig <= (s == 2) ? 3'h2 : 3'h0;
			#1 wait_lvl(0, 1'h1);
			wait_lvl(0, 1'h0);
			repeat (20) @(posedge core_clk);
			check({7'h0, cnv}, 8'h00);
			rd(4'h0, 8'he8, 8'ha0 | 8'(s << 2));
			@(posedge core_clk) trig <= 3'h0;
		end
		$display("start source test done");
	endtask : t_sources
	task t_track;
		wr(4'h0, 8'he8, 8'hc0);
		check({7'h0, trk}, 8'h00);
		wr(4'h0, 8'he8, 8'hd0);
		check({6'h0, trk, cnv}, 8'h02);
		wait_lvl(0, 1'h1);
		wait_lvl(0, 1'h0);
		rd(4'h0, 8'he8, 8'he0);
		$display("track mode test done");
	endtask : t_track
	task t_cal;
		for (int b = 0; b < 3; b++) begin
			wr(4'h0, 8'hbc, 8'h90 | 8'(1 << b));
			rd(4'h0, 8'hbc, 8'h90 | 8'(1 << b));
			wait_lvl(2, 1'h0);
			rd(4'h0, 8'hbc, 8'h90);
		end
		wr(4'h1, 8'hbc, 8'h91);
		check({7'h0, cal[1]}, 8'h01);
		rd(4'h1, 8'hbc, 8'h91);
		wait_lvl(5, 1'h0);
		rd(4'h1, 8'hbc, 8'h90);
		wr(4'h0, 8'he8, 8'hd0);
		wr(4'h0, 8'hbc, 8'h91);
		rd(4'h0, 8'hbc, 8'h90);
		wait_lvl(0, 1'h1);
		wait_lvl(0, 1'h0);
		wr(4'h0, 8'he8, 8'h00);
		wr(4'h0, 8'hbc, 8'h9f);
		rd(4'h0, 8'hbc, 8'h98);
		check({6'h0, pwr[0], xref[0]}, 8'h01);
		$display("calibration test done");
	endtask : t_cal
	initial begin
		rst_b = 1'h0;
		en1 = 1'h0;
		hit = 1'h0;
		trig = 3'h0;
		repeat (20) @(posedge core_clk);
		rst_b <= 1'h1;
		@(posedge core_clk);
		#1 t_reset;
		t_divider;
		t_sw_conv;
		t_sources;
		t_track;
		t_cal;
		give_verdict;
	end
endmodule : tb
